/* File: src/bspfc_pkg.sv */
// constants shared by both ends of the bridged serial port
// assumes a single 200 MHz clock on each end
package bspfc_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_MIN = 9_600;
  localparam int BAUD_MAX = 921_600;
  localparam int DATA_BITS = 8;
  localparam int TCP_DATA_PORT = 4901;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN);
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // control fields
  localparam int CTRL_RTS_BIT = 0;
  localparam int CTRL_CTS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status fields
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_SOCKET_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_FRAME_BIT = 3;
  localparam int ST_OVERRUN_BIT = 4;
  // synchroniser reset image: {ready level, enable, data line}
  localparam logic [2:0] SYNC_RESET = 3'h5;
endpackage

/* File: src/bspfc_link_if.sv */
// serial link between the board-controller end and the target end
// assumes both ends share the testbench clock; ready lines idle high when undriven
`timescale 1ns/10ps
`default_nettype none
interface bspfc_link_if;
  logic t2c_line;
  logic c2t_line;
  logic link_enable;
  logic ctrl_rdy_n;
  logic ctrl_rdy_oe;
  logic tgt_rdy_n;
  logic tgt_rdy_oe;
  logic ctrl_rdy_level;
  logic tgt_rdy_level;
  // pull-up when nobody drives: reads as deasserted
  assign ctrl_rdy_level = ctrl_rdy_oe ? ctrl_rdy_n : 1'b1;
  assign tgt_rdy_level = tgt_rdy_oe ? tgt_rdy_n : 1'b1;
  modport ctrl_end (
    input t2c_line, link_enable, tgt_rdy_level,
    output c2t_line, ctrl_rdy_n, ctrl_rdy_oe
  );
  modport target_end (
    input c2t_line, ctrl_rdy_level,
    output t2c_line, link_enable, tgt_rdy_n, tgt_rdy_oe
  );
endinterface
`default_nettype wire

/* File: src/bspfc_ctrl_end.sv */
// board-controller end of the bridged serial port, with the shared
// serialiser, deserialiser and small buffer used by both ends
// assumes an APB master on clk and host channels on the same clock
//
// What this block does
// - each side drives its own data line
// - default 115200 baud, 8N1, handshake off
// - baud settable from 9600 to 921600
// - each flow line switchable on or off
// - controller-ready asserted while able to receive
// - target-ready asserted while target can accept
// - data passes only while enable is active
// - forward target bytes to host, host bytes out
// - one host channel, socket over usb
// - full buffer drops controller-ready
// - byte in progress always completes
// - target-ready ignored when its handshake off
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module bspfc_tx
  import bspfc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic [15:0] div, // clocks per bit
  input wire logic go, // may start a new byte
  input wire logic in_valid, // byte offered
  output logic in_ready, // byte taken
  input wire logic [7:0] in_data, // byte
  output logic line // serial out
);
  typedef enum logic [1:0] {T_IDLE, T_START, T_DATA, T_STOP} bspfc_tx_type;
  bspfc_tx_type state_reg;
  logic [15:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;

  assign in_ready = (state_reg == T_IDLE) && go;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= T_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      line <= 1'b1;
    end else begin
      unique case (state_reg)
        T_IDLE: begin
          line <= 1'b1;
          if (in_valid && in_ready) begin
            sh_reg <= in_data;
            cnt_reg <= div - 16'h0001;
            line <= 1'b0;
            state_reg <= T_START;
          end
        end
        T_START, T_DATA: begin
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else begin
            cnt_reg <= div - 16'h0001;
            if (state_reg == T_DATA && bit_reg == 3'(DATA_BITS - 1)) begin
              line <= 1'b1;
              state_reg <= T_STOP;
            end else begin
              if (state_reg == T_DATA) begin
                bit_reg <= bit_reg + 3'h1;
              end
              line <= state_reg == T_START ? sh_reg[0] : sh_reg[1];
              if (state_reg == T_DATA) begin
                sh_reg <= {1'b0, sh_reg[7:1]};
              end
              state_reg <= T_DATA;
            end
          end
        end
        T_STOP: begin
          bit_reg <= 3'h0;
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else begin
            state_reg <= T_IDLE;
          end
        end
      endcase
    end
  end
endmodule

module bspfc_rx
  import bspfc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic [15:0] div, // clocks per bit
  input wire logic line, // synchronised serial in
  output logic out_valid, // one-cycle byte strobe
  output logic [7:0] out_data, // received byte
  output logic frame_err // one-cycle bad stop strobe
);
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} bspfc_rx_type;
  bspfc_rx_type state_reg;
  logic [15:0] cnt_reg;
  logic [2:0] bit_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= R_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      out_data <= 8'h00;
      out_valid <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      frame_err <= 1'b0;
      if (state_reg != R_IDLE && cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else begin
        unique case (state_reg)
          R_IDLE: begin
            bit_reg <= 3'h0;
            if (!line) begin
              cnt_reg <= {1'b0, div[15:1]}; // sample mid-bit
              state_reg <= R_START;
            end
          end
          R_START: begin
            cnt_reg <= div - 16'h0001;
            state_reg <= line ? R_IDLE : R_DATA;
          end
          R_DATA: begin
            cnt_reg <= div - 16'h0001;
            out_data <= {line, out_data[7:1]};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'(DATA_BITS - 1)) begin
              state_reg <= R_STOP;
            end
          end
          R_STOP: begin
            out_valid <= line;
            frame_err <= !line;
            state_reg <= R_IDLE;
          end
        endcase
      end
    end
  end
endmodule

module bspfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic in_valid, // write offered
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // not empty
  input wire logic out_ready, // reader takes
  output logic [WIDTH-1:0] out_data, // head entry
  output logic [$clog2(DEPTH+1)-1:0] count // entries held
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic push;
  logic pop;

  if (DEPTH < 2) begin : g_check
    $error("bspfc_fifo needs DEPTH of at least 2");
  end

  assign in_ready = count != ($clog2(DEPTH+1))'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + PW'(1);
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + PW'(1);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end
endmodule

module bspfc_ctrl_end
  import bspfc_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sock_connected, // tcp socket attached
  input wire logic usb_h2t_valid, // usb byte to target
  output logic usb_h2t_ready, // usb byte taken
  input wire logic [7:0] usb_h2t_data, // usb byte
  input wire logic tcp_h2t_valid, // tcp byte to target
  output logic tcp_h2t_ready, // tcp byte taken
  input wire logic [7:0] tcp_h2t_data, // tcp byte
  output logic usb_t2h_valid, // byte for usb host
  input wire logic usb_t2h_ready, // usb host takes
  output logic tcp_t2h_valid, // byte for tcp host
  input wire logic tcp_t2h_ready, // tcp host takes
  output logic [7:0] t2h_data, // byte to host
  bspfc_link_if.ctrl_end link // serial link
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [1:0] ctrl_reg;
  logic [15:0] div_reg;
  logic frame_reg;
  logic overrun_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic en_s;
  logic tgt_rdy_s;
  logic rx_line;
  logic rx_valid;
  logic rx_ferr;
  logic [7:0] rx_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [CW-1:0] fifo_count;
  logic tx_go;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic wr_en;
  logic clr_frame;
  logic clr_overrun;
  logic [15:0] div_next;

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_DIV || a == REG_STATUS;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {link.tgt_rdy_level, link.link_enable, link.t2c_line};
      sync2_reg <= sync1_reg;
    end
  end
  assign en_s = sync2_reg[1];
  assign tgt_rdy_s = !sync2_reg[2];
  assign rx_line = en_s ? sync2_reg[0] : 1'b1;

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wr_en = psel && penable && pwrite;
  assign clr_frame = wr_en && paddr == REG_STATUS && pwdata[ST_FRAME_BIT];
  assign clr_overrun = wr_en && paddr == REG_STATUS && pwdata[ST_OVERRUN_BIT];
  // out-of-range divisors are clamped into the served baud range
  assign div_next = pwdata[15:0] < DIV_MIN ? DIV_MIN :
                    pwdata[15:0] > DIV_MAX ? DIV_MAX : pwdata[15:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      div_reg <= DIV_DEFAULT;
    end else if (wr_en) begin
      if (paddr == REG_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == REG_DIV) begin
        div_reg <= div_next;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      frame_reg <= rx_ferr || (frame_reg && !clr_frame);
      overrun_reg <= (rx_valid && !fifo_in_ready) || (overrun_reg && !clr_overrun);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        REG_CTRL: prdata[1:0] <= ctrl_reg;
        REG_DIV: prdata[15:0] <= div_reg;
        REG_STATUS: begin
          prdata[ST_ENABLE_BIT] <= en_s;
          prdata[ST_SOCKET_BIT] <= sock_connected;
          prdata[ST_FULL_BIT] <= !fifo_in_ready;
          prdata[ST_FRAME_BIT] <= frame_reg;
          prdata[ST_OVERRUN_BIT] <= overrun_reg;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // target to host
  bspfc_rx u_rx (
    .clk(clk), .rst(rst), .div(div_reg), .line(rx_line),
    .out_valid(rx_valid), .out_data(rx_data), .frame_err(rx_ferr)
  );

  bspfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_buf (
    .clk(clk), .rst(rst), .in_valid(rx_valid), .in_ready(fifo_in_ready),
    .in_data(rx_data), .out_valid(fifo_out_valid), .out_ready(fifo_out_ready),
    .out_data(t2h_data), .count(fifo_count)
  );

  assign fifo_out_ready = sock_connected ? tcp_t2h_ready : usb_t2h_ready;
  assign tcp_t2h_valid = fifo_out_valid && sock_connected;
  assign usb_t2h_valid = fifo_out_valid && !sock_connected;

  // ready drops with one slot left so a byte already in flight still fits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.ctrl_rdy_n <= 1'b1;
    end else begin
      link.ctrl_rdy_n <= !(en_s && fifo_count < CW'(DEPTH - 1));
    end
  end
  assign link.ctrl_rdy_oe = ctrl_reg[CTRL_RTS_BIT];

  // host to target
  assign tx_valid = sock_connected ? tcp_h2t_valid : usb_h2t_valid;
  assign tx_data = sock_connected ? tcp_h2t_data : usb_h2t_data;
  assign tcp_h2t_ready = tx_ready && sock_connected;
  assign usb_h2t_ready = tx_ready && !sock_connected;
  assign tx_go = en_s && (!ctrl_reg[CTRL_CTS_BIT] || tgt_rdy_s);

  bspfc_tx u_tx (
    .clk(clk), .rst(rst), .div(div_reg), .go(tx_go), .in_valid(tx_valid),
    .in_ready(tx_ready), .in_data(tx_data), .line(link.c2t_line)
  );
endmodule
`default_nettype wire

/* File: src/bspfc_target_end.sv */
// target uart end of the bridged serial port
// assumes bspfc_tx, bspfc_rx and bspfc_fifo are compiled before this file
`timescale 1ns/10ps
`default_nettype none
module bspfc_target_end
  import bspfc_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic [15:0] div, // clocks per bit
  input wire logic enable_in, // drive link enable
  input wire logic rts_en, // drive target-ready line
  input wire logic cts_en, // obey controller-ready line
  input wire logic tx_valid, // byte to send
  output logic tx_ready, // byte taken
  input wire logic [7:0] tx_data, // byte
  output logic rx_valid, // received byte available
  input wire logic rx_ready, // user takes byte
  output logic [7:0] rx_data, // received byte
  bspfc_link_if.target_end link // serial link
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic en_reg;
  logic rx_line;
  logic rx_strobe;
  logic [7:0] rx_byte;
  logic [CW-1:0] fifo_count;
  logic tx_go;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      en_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.ctrl_rdy_level, link.c2t_line};
      sync2_reg <= sync1_reg;
      en_reg <= enable_in;
    end
  end
  assign link.link_enable = en_reg;
  assign rx_line = en_reg ? sync2_reg[0] : 1'b1;

  bspfc_rx u_rx (
    .clk(clk), .rst(rst), .div(div), .line(rx_line),
    .out_valid(rx_strobe), .out_data(rx_byte), .frame_err()
  );

  bspfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_buf (
    .clk(clk), .rst(rst), .in_valid(rx_strobe), .in_ready(),
    .in_data(rx_byte), .out_valid(rx_valid), .out_ready(rx_ready),
    .out_data(rx_data), .count(fifo_count)
  );

  // keep a free slot for the byte the controller may still finish
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.tgt_rdy_n <= 1'b1;
    end else begin
      link.tgt_rdy_n <= !(en_reg && fifo_count < CW'(DEPTH - 1));
    end
  end
  assign link.tgt_rdy_oe = rts_en;

  assign tx_go = en_reg && (!cts_en || !sync2_reg[1]);
  bspfc_tx u_tx (
    .clk(clk), .rst(rst), .div(div), .go(tx_go), .in_valid(tx_valid),
    .in_ready(tx_ready), .in_data(tx_data), .line(link.t2c_line)
  );
endmodule
`default_nettype wire

/* File: verif/bspfc_link_props.sv */
// wire-level assertions on the link between the two ends
// assumes one clock, BIT equal to the divider used for all traffic, and
// the target obeying controller-ready whenever the controller drives it
`timescale 1ns/10ps
`default_nettype none
module bspfc_link_props #(
  parameter int BIT = 217
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic t2c_line, // target to controller data
  input wire logic c2t_line, // controller to target data
  input wire logic link_enable, // link enable
  input wire logic ctrl_rdy_n, // controller ready, registered
  input wire logic ctrl_rdy_oe, // controller ready drive
  input wire logic ctrl_rdy_level // controller ready wire
);
  localparam int MID = BIT / 2;
  localparam int STOP = 9 * BIT + BIT / 2;
  localparam int FRAME = 10 * BIT - 2;
  logic [15:0] c2t_cnt;
  logic [15:0] t2c_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // frame position, zero while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c2t_cnt <= 16'h0000;
    end else if (c2t_cnt == 16'(FRAME)) begin
      c2t_cnt <= 16'h0000;
    end else if (c2t_cnt != 16'h0000 || $fell(c2t_line)) begin
      c2t_cnt <= c2t_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t2c_cnt <= 16'h0000;
    end else if (t2c_cnt == 16'(FRAME)) begin
      t2c_cnt <= 16'h0000;
    end else if (t2c_cnt != 16'h0000 || $fell(t2c_line)) begin
      t2c_cnt <= t2c_cnt + 16'h0001;
    end
  end

  sequence c2t_go_s;
    c2t_cnt == 16'h0000 && $fell(c2t_line);
  endsequence
  sequence t2c_go_s;
    t2c_cnt == 16'h0000 && $fell(t2c_line);
  endsequence

  AST_C2T_START: assert property (c2t_cnt == 16'(MID) |-> !c2t_line)
    else $error("c2t start bit not low");
  AST_C2T_STOP: assert property (c2t_cnt == 16'(STOP) |-> c2t_line)
    else $error("c2t stop bit not high");
  AST_T2C_START: assert property (t2c_cnt == 16'(MID) |-> !t2c_line)
    else $error("t2c start bit not low");
  AST_T2C_STOP: assert property (t2c_cnt == 16'(STOP) |-> t2c_line)
    else $error("t2c stop bit not high");
  AST_C2T_GATED: assert property (c2t_go_s |-> link_enable || $past(link_enable, 4))
    else $error("c2t frame while link disabled");
  AST_T2C_GATED: assert property (t2c_go_s |-> link_enable || $past(link_enable, 4))
    else $error("t2c frame while link disabled");
  AST_T2C_HALT: assert property (t2c_go_s ##0 ctrl_rdy_oe |-> !ctrl_rdy_level)
    else $error("t2c frame while controller not ready");
  AST_RST_IDLE: assert property ($fell(rst) |-> c2t_line && t2c_line && ctrl_rdy_n && !ctrl_rdy_oe)
    else $error("link not idle after reset");
endmodule
`default_nettype wire

/* File: verif/bridged_serial_port_flow_control_test.sv */
// self-checking bench: both ends joined over the link interface
// assumes DIV is set to DIV_MIN before any serial traffic
`timescale 1ns/10ps
`default_nettype none
module bridged_serial_port_flow_control_test
  import bspfc_pkg::*;
();
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sock = 1'b0;
  logic [7:0] paddr = 8'h00, h2t_data = 8'h00, tx_data = 8'h00, t2h_data, rx_data;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, usb_h2t_ready, tcp_h2t_ready, usb_t2h_valid, tcp_t2h_valid;
  logic usb_h2t_valid = 1'b0, tcp_h2t_valid = 1'b0, usb_t2h_ready = 1'b0, tcp_t2h_ready = 1'b0;
  logic enable_in = 1'b0, rts_en = 1'b0, cts_en = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic tx_ready, rx_valid;
  logic [15:0] div = DIV_MIN;
  int fails = 0, n_checks = 0;
  always #2.5 clk = ~clk;

  bspfc_link_if link ();
  bspfc_ctrl_end u_bspfc_ctrl_end (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sock_connected(sock), .usb_h2t_valid(usb_h2t_valid),
    .usb_h2t_ready(usb_h2t_ready), .usb_h2t_data(h2t_data), .tcp_h2t_valid(tcp_h2t_valid),
    .tcp_h2t_ready(tcp_h2t_ready), .tcp_h2t_data(h2t_data), .usb_t2h_valid(usb_t2h_valid),
    .usb_t2h_ready(usb_t2h_ready), .tcp_t2h_valid(tcp_t2h_valid),
    .tcp_t2h_ready(tcp_t2h_ready), .t2h_data(t2h_data), .link(link));
  bspfc_target_end u_bspfc_target_end (.clk(clk), .rst(rst), .div(div), .enable_in(enable_in),
    .rts_en(rts_en), .cts_en(cts_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .link(link));
  bspfc_link_props #(.BIT(int'(DIV_MIN))) u_bspfc_link_props (.clk(clk), .rst(rst),
    .t2c_line(link.t2c_line), .c2t_line(link.c2t_line), .link_enable(link.link_enable),
    .ctrl_rdy_n(link.ctrl_rdy_n), .ctrl_rdy_oe(link.ctrl_rdy_oe),
    .ctrl_rdy_level(link.ctrl_rdy_level));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // 0 apb, 1/2 usb/tcp push, 3/4 usb/tcp pop, 5 target push, 6 target pop
  function automatic logic seen_hi(input int s);
    case (s)
      0: return pready;
      1: return usb_h2t_ready;
      2: return tcp_h2t_ready;
      3: return usb_t2h_valid;
      4: return tcp_t2h_valid;
      5: return tx_ready;
      default: return rx_valid;
    endcase
  endfunction

  // samples at rising edges; the edge that sees it high completes the handshake
  task automatic wait_for(input int s, input int lim, input bit must, output bit ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < lim && !ok; i++) begin
      @(posedge clk);
      ok = (seen_hi(s) === 1'b1);
    end
    if (must && !ok) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic drive(input int s, input logic v, input logic [7:0] d);
    case (s)
      1: usb_h2t_valid <= v;
      2: tcp_h2t_valid <= v;
      3: usb_t2h_ready <= v;
      4: tcp_t2h_ready <= v;
      5: tx_valid <= v;
      default: rx_ready <= v;
    endcase
    // only the sender's data bus follows, so a receiver never disturbs a held byte
    if (v && (s == 1 || s == 2)) begin
      h2t_data <= d;
    end
    if (v && s == 5) begin
      tx_data <= d;
    end
  endtask

  task automatic xfer(input int s, input logic [7:0] d, input string what);
    bit ok;
    logic [7:0] q;
    drive(s, 1'b1, d);
    wait_for(s, 6000, 1'b1, ok);
    q = (s == 6) ? rx_data : t2h_data;
    if (s == 3 || s == 4 || s == 6) begin
      check(what, 32'(q), 32'(d));
    end
    drive(s, 1'b0, d);
    @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    bit ok;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    wait_for(0, 50, 1'b1, ok);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, exp);
  endtask

  initial begin
    logic [31:0] q;
    logic e;
    bit ok;
    int ch;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h0, "ctrl reset");
    rd(REG_DIV, 32'(DIV_DEFAULT), "div reset");
    rd(REG_STATUS, 32'h0, "status reset");
    apb(1'b0, 8'h0C, 32'h0, q, e);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", q, 32'h0);
    wr(REG_DIV, 32'h64);
    rd(REG_DIV, 32'(DIV_MIN), "div low clamp");
    wr(REG_DIV, 32'hFFFF);
    rd(REG_DIV, 32'(DIV_MAX), "div high clamp");
    wr(REG_DIV, 32'(DIV_MIN));
    wr(REG_CTRL, 32'hFFFFFFFF);
    rd(REG_CTRL, 32'h3, "ctrl fields");
    wr(REG_CTRL, 32'h0);
    $display("registers done");
    fork
      xfer(5, 8'h96, "");
      begin
        wait_for(3, 3000, 1'b0, ok);
        check("host byte while disabled", 32'(ok), 32'h0);
        @(posedge clk);
        enable_in <= 1'b1;
      end
    join
    xfer(3, 8'h96, "usb byte after enable");
    rd(REG_STATUS, 32'h1, "status enabled");
    $display("enable done");
    for (ch = 0; ch < 2; ch++) begin
      @(posedge clk);
      sock <= ch[0];
      xfer(1 + ch, 8'hA5 ^ 8'(ch), "");
      xfer(6, 8'hA5 ^ 8'(ch), "target byte");
      xfer(5, 8'h3C + 8'(ch), "");
      wait_for(3 + ch, 6000, 1'b1, ok);
      check("idle valid", 32'(ch[0] ? usb_t2h_valid : tcp_t2h_valid), 32'h0);
      check("idle ready", 32'(ch[0] ? usb_h2t_ready : tcp_h2t_ready), 32'h0);
      xfer(3 + ch, 8'h3C + 8'(ch), "host byte");
    end
    rd(REG_STATUS, 32'h3, "status socket");
    sock <= 1'b0;
    cts_en <= 1'b1;
    wr(REG_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    check("ctrl ready asserted", 32'(link.ctrl_rdy_level), 32'h0);
    $display("channels done");
    xfer(5, 8'h11, "");
    fork
      xfer(5, 8'h22, "");
      begin
        wait_for(3, 6000, 1'b1, ok);
        repeat (2300) @(posedge clk);
        check("ctrl ready dropped", 32'(link.ctrl_rdy_level), 32'h1);
        rd(REG_STATUS, 32'h1, "no overrun with flow");
        xfer(3, 8'h11, "first held byte");
        xfer(3, 8'h22, "second held byte");
      end
    join
    wr(REG_CTRL, 32'h0);
    cts_en <= 1'b0;
    xfer(5, 8'h33, "");
    xfer(5, 8'h44, "");
    xfer(5, 8'h55, "");
    repeat (2300) @(posedge clk);
    rd(REG_STATUS, 32'h15, "overrun without flow");
    xfer(3, 8'h33, "first kept byte");
    xfer(3, 8'h44, "second kept byte");
    wr(REG_STATUS, 32'h10);
    rd(REG_STATUS, 32'h1, "overrun cleared");
    $display("controller flow done");
    wr(REG_CTRL, 32'h2);
    fork
      xfer(1, 8'h5A, "");
      begin
        wait_for(6, 3000, 1'b0, ok);
        check("c2t held by target ready", 32'(ok), 32'h0);
        @(posedge clk);
        rts_en <= 1'b1;
      end
    join
    xfer(6, 8'h5A, "released byte");
    repeat (4) @(posedge clk);
    check("target ready asserted", 32'(link.tgt_rdy_level), 32'h0);
    xfer(1, 8'hC3, "");
    rts_en <= 1'b0;
    xfer(6, 8'hC3, "byte in flight completes");
    $display("target flow done");
    stop_test();
  end
endmodule
`default_nettype wire
